// [mbs_frame_handler.sv]
// slave-side request frame handler: receive, check, access registers, answer
// assumes a byte receiver and transmitter on mclk_i and an external register map
// Behaviour
// - write checked only against register data length; checksum follows data
// - two-byte write frame has its checksum in bytes 6 and 7
// - frame too long, or too short but at least 4 bytes, fails checksum and gets error reply
// - coil word is 0x0000 for false, 0xFF00 for true
// - single register write answered by 8-byte echo with fresh checksum
// - single coil write answered by echo of register and coil word
// - multiple write: count equals twice number; reply start and number
// - register read reply: length byte at byte 2, data, checksum last
// - coil read reply: byte count 2, one word, checksum
// - error reply: address, function plus 0x80, error code, checksum
// - code 0x01 for unsupported function or function undefined for register
// - code 0x02 for register address undefined for the unit
// - code 0x03 for wrong data length or out-of-range value
// - code 0x04 when a valid command cannot execute now
// - code 0x05 for bad checksum, including swapped byte order
// - code 0x07 for forbidden direction, not remote, or other interface
// - code 0x17 for writes while local; reads still allowed
// - coil read through holding-register read is a format error
// - refused request is not performed; error frame replaces confirmation
// - checksum is reflected CRC16, start 0xFFFF, polynomial 0xA001
// - checksum sent low byte first
// - other multi-byte fields go most significant byte first
// - writes accepted only under remote control
`include "mbs_cfg.svh"
module mbs_frame_handler
  import mbs_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = `MBS_GAP_CYCLES
)
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic        remote_i,
  input  wire logic        local_i,
  input  wire logic        other_if_i,
  output logic             reg_req_o,
  output logic             reg_we_o,
  output logic             reg_check_o,
  output logic             reg_coil_o,
  output logic      [15:0] reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic        reg_ack_i,
  input  wire logic [7:0]  reg_status_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             busy_o
);
  logic [7:0]    rx_buf [`MBS_BUF_DEPTH];
  logic [7:0]    tx_buf [`MBS_BUF_DEPTH];
  mbs_state_type state_q;
  logic [8:0]    rx_len_q;
  logic [15:0]   rx_crc_q;
  logic [31:0]   gap_q;
  logic [7:0]    err_q;
  logic          drop_q;
  logic          wr_q;
  logic          commit_q;
  logic [15:0]   idx_q;
  logic [15:0]   num_q;
  logic [8:0]    tx_len_q;
  logic [8:0]    tidx_q;
  logic [15:0]   tx_crc_q;

  logic [7:0]    fc;
  logic [15:0]   start_reg;
  logic [15:0]   word;
  logic [7:0]    count;
  logic          fc_known;
  logic          is_write;
  logic [8:0]    exp_len;
  logic          frame_end;
  logic [15:0]   req_idx;
  logic [15:0]   next_idx;
  logic [8:0]    data_pos;

  assign fc        = rx_buf[`MBS_POS_FC];
  assign start_reg = {rx_buf[`MBS_POS_REG_HI], rx_buf[`MBS_POS_REG_LO]};
  assign word      = {rx_buf[`MBS_POS_WORD_HI], rx_buf[`MBS_POS_WORD_LO]};
  assign count     = rx_buf[`MBS_POS_COUNT];
  assign fc_known  = (fc == `MBS_FC_RD_COIL) || (fc == `MBS_FC_RD_HOLD) ||
                     (fc == `MBS_FC_WR_COIL) || (fc == `MBS_FC_WR_REG) ||
                     (fc == `MBS_FC_WR_MULTI);
  assign is_write  = (fc == `MBS_FC_WR_COIL) || (fc == `MBS_FC_WR_REG) ||
                     (fc == `MBS_FC_WR_MULTI);
  assign frame_end = (rx_len_q != 9'h000) && (gap_q >= GAP_CYCLES);
  assign next_idx  = idx_q + 16'h0001;

  // checksum is expected right after the data part; unknown codes check at the end
  always_comb
  begin
    if (fc == `MBS_FC_WR_MULTI)
      exp_len = `MBS_LEN_MULTI + {1'b0, count};
    else if (fc_known)
      exp_len = `MBS_LEN_FIXED;
    else
      exp_len = rx_len_q;
  end

  // index of the register word addressed by the next request
  always_comb
  begin
    if (state_q == MBS_CHECK)
      req_idx = 16'h0000;
    else if (next_idx == num_q)
      req_idx = 16'h0000;
    else
      req_idx = next_idx;
    data_pos = 9'(`MBS_POS_DATA) + {req_idx[7:0], 1'b0};
  end

  // receive path, open only while idle: the link is half duplex
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rx_len_q <= 9'h000;
      rx_crc_q <= `MBS_CRC_INIT;
      gap_q    <= 32'h0000_0000;
    end
    else if (state_q == MBS_IDLE && rx_valid_i)
    begin
      if (rx_len_q != `MBS_LEN_SAT)
        rx_len_q <= rx_len_q + 9'h001;
      rx_crc_q <= mbs_crc_step(rx_crc_q, rx_data_i);
      gap_q    <= 32'h0000_0000;
    end
    else if (state_q == MBS_IDLE)
    begin
      if (rx_len_q != 9'h000 && gap_q < GAP_CYCLES)
        gap_q <= gap_q + 32'h0000_0001;
    end
    else if (state_q == MBS_FINISH)
    begin
      rx_len_q <= 9'h000;
      rx_crc_q <= `MBS_CRC_INIT;
      gap_q    <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (state_q == MBS_IDLE && rx_valid_i && rx_len_q < 9'(`MBS_BUF_DEPTH))
      rx_buf[rx_len_q[7:0]] <= rx_data_i;
  end

  // decision, register access sequencing and transmit sequencing
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_q     <= MBS_IDLE;
      err_q       <= `MBS_ERR_NONE;
      drop_q      <= 1'b0;
      wr_q        <= 1'b0;
      commit_q    <= 1'b0;
      idx_q       <= 16'h0000;
      num_q       <= 16'h0000;
      tx_len_q    <= 9'h000;
      tidx_q      <= 9'h000;
      tx_crc_q    <= `MBS_CRC_INIT;
      reg_req_o   <= 1'b0;
      reg_we_o    <= 1'b0;
      reg_check_o <= 1'b0;
      reg_coil_o  <= 1'b0;
      reg_addr_o  <= 16'h0000;
      reg_wdata_o <= 16'h0000;
      tx_data_o   <= 8'h00;
      tx_valid_o  <= 1'b0;
      busy_o      <= 1'b0;
    end
    else
    begin
      reg_req_o <= 1'b0;
      unique case (state_q)
        MBS_IDLE:
        begin
          if (frame_end)
          begin
            state_q <= MBS_CHECK;
            busy_o  <= 1'b1;
          end
        end
        MBS_CHECK:
        begin
          err_q    <= `MBS_ERR_NONE;
          drop_q   <= 1'b0;
          wr_q     <= is_write;
          commit_q <= !is_write;
          idx_q    <= 16'h0000;
          num_q    <= (fc == `MBS_FC_WR_MULTI || fc == `MBS_FC_RD_HOLD) ? word : 16'h0001;
          state_q  <= MBS_FINISH;
          // frames not opened by a zero byte belong to the text protocol
          if (rx_buf[`MBS_POS_ADDR] != 8'h00 || rx_len_q < `MBS_LEN_MIN)
            drop_q <= 1'b1;
          else if (rx_len_q != exp_len || rx_crc_q != `MBS_CRC_RESIDUE)
            err_q <= `MBS_ERR_CRC;
          else if (!fc_known)
            err_q <= `MBS_ERR_FUNC;
          else if ((fc == `MBS_FC_WR_MULTI &&
                    (word == 16'h0000 || word > `MBS_MULTI_MAX ||
                     {8'h00, count} != {word[14:0], 1'b0})) ||
                   (fc == `MBS_FC_RD_HOLD &&
                    (word == 16'h0000 || word > `MBS_HOLD_MAX)) ||
                   (fc == `MBS_FC_WR_COIL &&
                    word != `MBS_COIL_OFF && word != `MBS_COIL_ON))
            err_q <= `MBS_ERR_DATA;
          else if (is_write && local_i)
            err_q <= `MBS_ERR_LOCAL;
          else if (is_write && (!remote_i || other_if_i))
            err_q <= `MBS_ERR_ACCESS;
          else
          begin
            state_q     <= MBS_ACCESS;
            reg_req_o   <= 1'b1;
            reg_we_o    <= 1'b0;
            reg_check_o <= is_write;
            reg_coil_o  <= (fc == `MBS_FC_RD_COIL) || (fc == `MBS_FC_WR_COIL);
            reg_addr_o  <= start_reg;
            reg_wdata_o <= (fc == `MBS_FC_WR_MULTI) ?
                           {rx_buf[data_pos[7:0]], rx_buf[data_pos[7:0] + 8'h01]} : word;
          end
        end
        MBS_ACCESS:
        begin
          if (reg_ack_i)
          begin
            // map answers address, direction, range and situation faults
            if (reg_status_i != `MBS_ERR_NONE)
            begin
              err_q   <= reg_status_i;
              state_q <= MBS_FINISH;
            end
            else if (next_idx == num_q && commit_q)
              state_q <= MBS_FINISH;
            else
            begin
              // writes pass once as a dry check, so a refusal leaves nothing written
              if (next_idx == num_q)
                commit_q <= 1'b1;
              idx_q       <= req_idx;
              reg_req_o   <= 1'b1;
              reg_we_o    <= wr_q && (commit_q || next_idx == num_q);
              reg_check_o <= wr_q && !commit_q && next_idx != num_q;
              reg_addr_o  <= start_reg + req_idx;
              reg_wdata_o <= (fc == `MBS_FC_WR_MULTI) ?
                             {rx_buf[data_pos[7:0]], rx_buf[data_pos[7:0] + 8'h01]} : word;
            end
          end
        end
        MBS_FINISH:
        begin
          reg_we_o    <= 1'b0;
          reg_check_o <= 1'b0;
          tidx_q      <= 9'h000;
          tx_crc_q    <= `MBS_CRC_INIT;
          if (err_q != `MBS_ERR_NONE)
            tx_len_q <= `MBS_LEN_ERR;
          else if (wr_q)
            tx_len_q <= `MBS_LEN_ECHO;
          else
            tx_len_q <= 9'(`MBS_POS_RD_DATA) + {num_q[7:0], 1'b0};
          state_q <= drop_q ? MBS_IDLE : MBS_SEND;
          busy_o  <= !drop_q;
        end
        MBS_SEND:
        begin
          if (!tx_valid_o || tx_ready_i)
          begin
            tx_valid_o <= 1'b1;
            if (tidx_q < tx_len_q)
            begin
              tx_data_o <= tx_buf[tidx_q[7:0]];
              tx_crc_q  <= mbs_crc_step(tx_crc_q, tx_buf[tidx_q[7:0]]);
              tidx_q    <= tidx_q + 9'h001;
            end
            else
            begin
              tx_data_o <= tx_crc_q[7:0];
              state_q   <= MBS_CRC_LO;
            end
          end
        end
        MBS_CRC_LO:
        begin
          if (tx_ready_i)
          begin
            tx_data_o <= tx_crc_q[15:8];
            state_q   <= MBS_CRC_HI;
          end
        end
        MBS_CRC_HI:
        begin
          if (tx_ready_i)
          begin
            tx_valid_o <= 1'b0;
            busy_o     <= 1'b0;
            state_q    <= MBS_IDLE;
          end
        end
        default:
        begin
          state_q <= MBS_IDLE;
        end
      endcase
    end
  end

  // answer assembly; read data lands in place as each word returns
  always_ff @(posedge mclk_i)
  begin
    if (state_q == MBS_ACCESS && reg_ack_i && reg_status_i == `MBS_ERR_NONE && !wr_q)
    begin
      tx_buf[8'(`MBS_POS_RD_DATA) + {idx_q[6:0], 1'b0}]         <= reg_rdata_i[15:8];
      tx_buf[8'(`MBS_POS_RD_DATA) + {idx_q[6:0], 1'b0} + 8'h01] <= reg_rdata_i[7:0];
    end
    else if (state_q == MBS_FINISH)
    begin
      tx_buf[`MBS_POS_ADDR] <= 8'h00;
      if (err_q != `MBS_ERR_NONE)
      begin
        tx_buf[`MBS_POS_FC]     <= fc | `MBS_FC_ERR_FLAG;
        tx_buf[`MBS_POS_RD_LEN] <= err_q;
      end
      else if (wr_q)
      begin
        tx_buf[`MBS_POS_FC]      <= fc;
        tx_buf[`MBS_POS_REG_HI]  <= rx_buf[`MBS_POS_REG_HI];
        tx_buf[`MBS_POS_REG_LO]  <= rx_buf[`MBS_POS_REG_LO];
        tx_buf[`MBS_POS_WORD_HI] <= rx_buf[`MBS_POS_WORD_HI];
        tx_buf[`MBS_POS_WORD_LO] <= rx_buf[`MBS_POS_WORD_LO];
      end
      else
      begin
        tx_buf[`MBS_POS_FC]     <= fc;
        tx_buf[`MBS_POS_RD_LEN] <= {num_q[6:0], 1'b0};
      end
    end
  end
endmodule : mbs_frame_handler

// [mbs_cfg.svh]
// constants of the frame handler: codes, positions, lengths, timing
// assumes inclusion by mbs_pkg and mbs_frame_handler only
`ifndef MBS_CFG_SVH
`define MBS_CFG_SVH
`define MBS_FC_RD_COIL   8'h01
`define MBS_FC_RD_HOLD   8'h03
`define MBS_FC_WR_COIL   8'h05
`define MBS_FC_WR_REG    8'h06
`define MBS_FC_WR_MULTI  8'h10
`define MBS_FC_ERR_FLAG  8'h80
`define MBS_ERR_NONE     8'h00
`define MBS_ERR_FUNC     8'h01
`define MBS_ERR_DATA     8'h03
`define MBS_ERR_CRC      8'h05
`define MBS_ERR_ACCESS   8'h07
`define MBS_ERR_LOCAL    8'h17
`define MBS_CRC_INIT     16'hFFFF
`define MBS_CRC_POLY     16'hA001
`define MBS_CRC_RESIDUE  16'h0000
`define MBS_COIL_OFF     16'h0000
`define MBS_COIL_ON      16'hFF00
`define MBS_POS_ADDR     0
`define MBS_POS_FC       1
`define MBS_POS_REG_HI   2
`define MBS_POS_REG_LO   3
`define MBS_POS_WORD_HI  4
`define MBS_POS_WORD_LO  5
`define MBS_POS_COUNT    6
`define MBS_POS_DATA     7
`define MBS_POS_RD_LEN   2
`define MBS_POS_RD_DATA  3
`define MBS_LEN_FIXED    9'h008
`define MBS_LEN_MULTI    9'h009
`define MBS_LEN_MIN      9'h004
`define MBS_LEN_ERR      9'h003
`define MBS_LEN_ECHO     9'h006
`define MBS_LEN_SAT      9'h1FF
`define MBS_BUF_DEPTH    256
`define MBS_HOLD_MAX     16'h007D
`define MBS_MULTI_MAX    16'h007B
`define MBS_CLK_NS       8
`define MBS_GAP_NS       1750000
`define MBS_GAP_CYCLES   ((`MBS_GAP_NS + `MBS_CLK_NS - 1) / `MBS_CLK_NS)
`endif

// [mbs_pkg.sv]
// types and the checksum step of the frame handler
// assumes mbs_cfg.svh in the include path
`include "mbs_cfg.svh"
package mbs_pkg;
  typedef enum logic [2:0] {
    MBS_IDLE   = 3'h0,
    MBS_CHECK  = 3'h1,
    MBS_ACCESS = 3'h3,
    MBS_FINISH = 3'h2,
    MBS_SEND   = 3'h6,
    MBS_CRC_LO = 3'h7,
    MBS_CRC_HI = 3'h5
  } mbs_state_type;

  function automatic logic [15:0] mbs_crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `MBS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mbs_crc_step
endpackage : mbs_pkg

// [mbs_host_model.sv]
// host-side partner: byte sink with optional stalls and a small register map
// assumes the frame handler's clock; requests are answered two cycles later
module mbs_host_model
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        stall_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic        reg_req_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_coil_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic             reg_ack_o,
  output logic [7:0]       reg_status_o,
  output logic [15:0]      reg_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tog_q = 1'b0;
  logic [1:0]  lat_q;
  logic [7:0]  got_q[$];
  int          commits = 0;
  logic [15:0] last_wdata_q;
  // slow mode takes a byte only every other cycle
  assign tx_ready_o = !stall_i || tog_q;
  always @(posedge mclk_i)
  begin
    tog_q <= ~tog_q;
    if (tx_valid_i && tx_ready_o)
      got_q.push_back(tx_data_i);
  end
  // answer lines toggle outside an ack so stale values never look valid
  always @(posedge mclk_i)
  begin
    reg_ack_o <= 1'b0;
    reg_status_o <= ~reg_status_o;
    reg_rdata_o <= ~reg_rdata_o;
    if (reset_i)
    begin
      lat_q <= 2'd0;
      reg_status_o <= 8'h00;
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_req_i)
    begin
      lat_q <= 2'd2;
      if (reg_we_i)
      begin
        commits <= commits + 1;
        last_wdata_q <= reg_wdata_i;
      end
    end
    else if (lat_q == 2'd1)
    begin
      lat_q <= 2'd0;
      reg_ack_o <= 1'b1;
      reg_status_o <= status_i;
      reg_rdata_o <= reg_coil_i ? 16'hFF00 : {reg_addr_i[7:0], ~reg_addr_i[7:0]};
    end
    else if (lat_q != 2'd0)
      lat_q <= lat_q - 2'd1;
  end
endmodule : mbs_host_model

// [mbs_frame_handler_chk.sv]
// concurrent checks on the frame handler's ports
// assumes a bind to mbs_frame_handler and a single clock domain
module mbs_frame_handler_chk
#(
  parameter int unsigned GAP_CYCLES = 20
)
(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic        remote_i,
  input wire logic        local_i,
  input wire logic        other_if_i,
  input wire logic        reg_req_o,
  input wire logic        reg_we_o,
  input wire logic        reg_check_o,
  input wire logic        reg_coil_o,
  input wire logic [15:0] reg_wdata_o,
  input wire logic        reg_ack_i,
  input wire logic [7:0]  reg_status_i,
  input wire logic        busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_q;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // idle cycles since the last byte the handler could take
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || (rx_valid_i && !busy_o))
      gap_q <= 32'h0;
    else if (gap_q != 32'hFFFFFFFF)
      gap_q <= gap_q + 32'h1;
  end
  a_tx_hold_byte: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed before accept");
  a_reply_addr_zero: assert property ($rose(tx_valid_o) |-> tx_data_o == 8'h00)
    else $error("reply does not start with address 0");
  a_req_one_pulse: assert property (reg_req_o |=> !reg_req_o)
    else $error("register request longer than one cycle");
  a_work_in_busy: assert property (reg_req_o || tx_valid_o |-> busy_o)
    else $error("activity outside busy");
  a_gap_before_busy: assert property ($rose(busy_o) |-> gap_q >= GAP_CYCLES)
    else $error("frame taken before idle gap");
  a_write_needs_remote: assert property (reg_req_o && (reg_we_o || reg_check_o) |-> remote_i && !local_i && !other_if_i)
    else $error("write request without remote control");
  a_coil_word_legal: assert property (reg_req_o && reg_we_o && reg_coil_o |-> reg_wdata_o inside {16'h0000, 16'hFF00})
    else $error("illegal coil word written");
  a_abort_no_req: assert property (reg_ack_i && reg_status_i != 8'h00 |=> !reg_req_o [*4])
    else $error("request after refused access");
  a_we_check_apart: assert property (reg_req_o |-> !(reg_we_o && reg_check_o))
    else $error("commit and dry run together");
endmodule : mbs_frame_handler_chk

bind mbs_frame_handler mbs_frame_handler_chk #(.GAP_CYCLES(GAP_CYCLES)) u_mbs_frame_handler_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .remote_i(remote_i), .local_i(local_i),
  .other_if_i(other_if_i), .reg_req_o(reg_req_o), .reg_we_o(reg_we_o),
  .reg_check_o(reg_check_o), .reg_coil_o(reg_coil_o), .reg_wdata_o(reg_wdata_o),
  .reg_ack_i(reg_ack_i), .reg_status_i(reg_status_i), .busy_o(busy_o));

// [tb_top.sv]
// self-checking bench: frames in, replies and register accesses judged
// assumes mbs_frame_handler, mbs_host_model and the checker compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mbs_bytes_type[$];
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  rx_data_i = 8'h00;
  logic        rx_valid_i = 1'b0;
  logic        remote_i = 1'b1;
  logic        local_i = 1'b0;
  logic        other_if_i = 1'b0;
  logic        stall = 1'b0;
  logic [7:0]  map_status = 8'h00;
  logic [7:0]  tx_data_o, reg_status_i;
  logic        tx_valid_o, tx_ready_i, reg_req_o, reg_we_o, reg_check_o, reg_coil_o;
  logic        reg_ack_i, busy_o;
  logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  int          miscompares = 0;
  int          checks = 0;
  int          cbase;
  always #4 mclk_i = ~mclk_i;
  mbs_frame_handler #(.GAP_CYCLES(20)) u_mbs_frame_handler (
    .mclk_i(mclk_i), .reset_i(reset_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .remote_i(remote_i), .local_i(local_i), .other_if_i(other_if_i), .reg_req_o(reg_req_o),
    .reg_we_o(reg_we_o), .reg_check_o(reg_check_o), .reg_coil_o(reg_coil_o),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_ack_i(reg_ack_i),
    .reg_status_i(reg_status_i), .reg_rdata_i(reg_rdata_i), .busy_o(busy_o));
  mbs_host_model u_mbs_host_model (
    .mclk_i(mclk_i), .reset_i(reset_i), .stall_i(stall), .status_i(map_status),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
    .reg_req_i(reg_req_o), .reg_we_i(reg_we_o), .reg_coil_i(reg_coil_o),
    .reg_addr_i(reg_addr_o), .reg_wdata_i(reg_wdata_o), .reg_ack_o(reg_ack_i),
    .reg_status_o(reg_status_i), .reg_rdata_o(reg_rdata_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] crc16(input mbs_bytes_type f);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i])
    begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  function automatic logic [15:0] ncommit();
    return 16'(u_mbs_host_model.commits - cbase);
  endfunction : ncommit
  task automatic put(input logic [7:0] b);
    @(posedge mclk_i);
    #1;
    rx_data_i = b;
    rx_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
    rx_valid_i = 1'b0;
    rx_data_i = ~b;
  endtask : put
  // frame out with checksum, then the whole reply compared byte for byte
  task automatic xfer(input mbs_bytes_type f, input mbs_bytes_type e, input bit swap);
    logic [15:0] c;
    int          k0;
    int          n;
    c = crc16(f);
    k0 = u_mbs_host_model.got_q.size();
    cbase = u_mbs_host_model.commits;
    foreach (f[i])
      put(f[i]);
    put(swap ? c[15:8] : c[7:0]);
    put(swap ? c[7:0] : c[15:8]);
    n = 0;
    while (busy_o !== 1'b1 && n < 300)
    begin
      @(posedge mclk_i);
      n++;
    end
    // a frame that never starts or never ends counts against the run
    chk({15'h0000, n < 300}, 16'h0001);
    while (busy_o !== 1'b0 && n < 3000)
    begin
      @(posedge mclk_i);
      n++;
    end
    #1;
    chk({15'h0000, n < 3000}, 16'h0001);
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk(16'(u_mbs_host_model.got_q.size() - k0), 16'(e.size()));
    foreach (e[i])
      chk({8'h00, u_mbs_host_model.got_q[k0 + i]}, {8'h00, e[i]});
  endtask : xfer
  task automatic final_report;
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic t_write;
    mbs_bytes_type w = '{8'h00, 8'h06, 8'h01, 8'hF5, 8'h66, 8'h66};
    mbs_bytes_type c = '{8'h00, 8'h05, 8'h01, 8'h92, 8'hFF, 8'h00};
    xfer(w, w, 1'b0);
    chk(ncommit(), 16'h0001);
    chk(u_mbs_host_model.last_wdata_q, 16'h6666);
    xfer(c, c, 1'b0);
    xfer('{8'h00, 8'h05, 8'h01, 8'h92, 8'h12, 8'h34}, '{8'h00, 8'h85, 8'h03}, 1'b0);
    chk(ncommit(), 16'h0000);
  endtask : t_write
  task automatic t_multi;
    stall = 1'b1;
    xfer('{8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'hAA, 8'hBB, 8'hCC, 8'hDD},
         '{8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02}, 1'b0);
    chk(ncommit(), 16'h0002);
    chk(u_mbs_host_model.last_wdata_q, 16'hCCDD);
    stall = 1'b0;
  endtask : t_multi
  task automatic t_read;
    local_i = 1'b1;
    xfer('{8'h00, 8'h03, 8'h00, 8'h20, 8'h00, 8'h02},
         '{8'h00, 8'h03, 8'h04, 8'h20, 8'hDF, 8'h21, 8'hDE}, 1'b0);
    xfer('{8'h00, 8'h06, 8'h00, 8'h20, 8'h00, 8'h01}, '{8'h00, 8'h86, 8'h17}, 1'b0);
    local_i = 1'b0;
    xfer('{8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h01},
         '{8'h00, 8'h01, 8'h02, 8'hFF, 8'h00}, 1'b0);
  endtask : t_read
  task automatic t_refuse;
    mbs_bytes_type w = '{8'h00, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34};
    xfer(w, '{8'h00, 8'h86, 8'h05}, 1'b1);
    xfer('{8'h00, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34, 8'h56},
         '{8'h00, 8'h86, 8'h05}, 1'b0);
    xfer('{8'h00, 8'h06, 8'h00, 8'h01, 8'h12}, '{8'h00, 8'h86, 8'h05}, 1'b0);
    xfer('{8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h03, 8'hAA, 8'hBB, 8'hCC},
         '{8'h00, 8'h90, 8'h03}, 1'b0);
    chk(ncommit(), 16'h0000);
    xfer('{8'h00, 8'h07, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h00, 8'h87, 8'h01}, 1'b0);
    remote_i = 1'b0;
    xfer(w, '{8'h00, 8'h86, 8'h07}, 1'b0);
    remote_i = 1'b1;
    other_if_i = 1'b1;
    xfer(w, '{8'h00, 8'h86, 8'h07}, 1'b0);
    other_if_i = 1'b0;
    map_status = 8'h02;
    xfer(w, '{8'h00, 8'h86, 8'h02}, 1'b0);
    chk(ncommit(), 16'h0000);
    map_status = 8'h04;
    xfer('{8'h00, 8'h05, 8'h01, 8'h92, 8'h00, 8'h00}, '{8'h00, 8'h85, 8'h04}, 1'b0);
    map_status = 8'h01;
    xfer('{8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, '{8'h00, 8'h83, 8'h01}, 1'b0);
    map_status = 8'h00;
  endtask : t_refuse
  initial
  begin
    repeat (5) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    t_write;
    t_multi;
    t_read;
    t_refuse;
    final_report;
  end
  // seventeen frames of under a hundred cycles each fit well inside this
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    final_report;
  end
endmodule : tb_top
